// [verilog/rlc_ctrl.sv]
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "rlc_params.svh"

module rlc_ctrl (
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  input  wire rlc_pkg::rlc_apb_req_t    apb_req,
  output      rlc_pkg::rlc_apb_rsp_t    apb_rsp,
  input  wire logic                     instr_cycle,
  input  wire logic [1:0]               cmp_decision,
  input  wire logic [1:0]               timer_clk,
  input  wire logic [1:0]               cmp_pin_direction,
  input  wire logic                     ref_pin_in,
  output      rlc_pkg::rlc_ladder_ctl_t ladder_ctl,
  output      logic                     ref_out_pin_oe,
  output      logic                     ref_out_pin_pullup_en,
  output      logic                     ref_out_pin_input_en,
  output      logic                     ref_pin_read,
  output      rlc_pkg::rlc_cmp_ctl_t [1:0] cmp_ctl,
  output      logic [1:0]               cmp_result_synced,
  output      logic [1:0]               cmp_result_raw,
  output      logic [1:0]               cmp_pin_out,
  output      logic [1:0]               cmp_pin_oe,
  output      logic [1:0]               cmp_event_flag
);
  import rlc_pkg::*;

  rlc_state_t s_q;
  rlc_state_t s_d;

  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [7:0]  rd_byte;
  logic [1:0]  raw;

  function automatic logic addr_hit(input logic [11:0] a);
    begin
      addr_hit = (a == `RLC_ADDR_REF_A) || (a == `RLC_ADDR_REF_LEVEL) ||
                 (a == `RLC_ADDR_CMP1_A) || (a == `RLC_ADDR_CMP1_B) ||
                 (a == `RLC_ADDR_CMP2_A) || (a == `RLC_ADDR_CMP2_B) ||
                 (a == `RLC_ADDR_CMP_OUT) || (a == `RLC_ADDR_CMP_FLAG);
    end
  endfunction : addr_hit

  // Zero-wait APB slave: every access completes in its first access cycle
  assign addr_ok = addr_hit(apb_req.paddr);
  assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en   = apb_req.psel && apb_req.penable && !apb_req.pwrite;

  // Raw decision is polarity-corrected and never latched
  always_comb begin
    for (int i = 0; i < `RLC_NUM_CMP; i++) begin
      raw[i] = s_q.cmp_a[i][`RLC_BIT_CMP_ON] &&
               (cmp_decision[i] ^ s_q.cmp_a[i][`RLC_BIT_CMP_INV]);
    end
  end

  always_comb begin
    rd_byte = 8'h0_0;
    unique case (apb_req.paddr)
      `RLC_ADDR_REF_A:     rd_byte = s_q.ref_a;
      `RLC_ADDR_REF_LEVEL: rd_byte = s_q.ref_level;
      `RLC_ADDR_CMP1_A:    rd_byte = {s_q.cmp_a[0][7], s_q.latched[0], s_q.cmp_a[0][5:0]};
      `RLC_ADDR_CMP1_B:    rd_byte = s_q.cmp_b[0];
      `RLC_ADDR_CMP2_A:    rd_byte = {s_q.cmp_a[1][7], s_q.latched[1], s_q.cmp_a[1][5:0]};
      `RLC_ADDR_CMP2_B:    rd_byte = s_q.cmp_b[1];
      `RLC_ADDR_CMP_OUT:   rd_byte = {6'h0_0, s_q.latched};
      `RLC_ADDR_CMP_FLAG:  rd_byte = {6'h0_0, s_q.flag};
      default:             rd_byte = 8'h0_0;
    endcase
  end

  always_comb begin
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok;
    apb_rsp.prdata  = (rd_en && addr_ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
  end

  always_comb begin
    logic edge_rise;
    logic edge_fall;
    logic set_ev;
    edge_rise = 1'b0;
    edge_fall = 1'b0;
    set_ev    = 1'b0;
    s_d = s_q;
    // Sleep has no effect here; control registers keep value until reset or write
    if (wr_en) begin
      unique case (apb_req.paddr)
        `RLC_ADDR_REF_A:     s_d.ref_a = apb_req.pwdata[7:0] & `RLC_REF_A_MASK;
        `RLC_ADDR_REF_LEVEL: s_d.ref_level = apb_req.pwdata[7:0] & `RLC_LEVEL_MASK;
        `RLC_ADDR_CMP1_A:    s_d.cmp_a[0] = apb_req.pwdata[7:0] & `RLC_CMP_A_MASK;
        `RLC_ADDR_CMP1_B:    s_d.cmp_b[0] = apb_req.pwdata[7:0] & `RLC_CMP_B_MASK;
        `RLC_ADDR_CMP2_A:    s_d.cmp_a[1] = apb_req.pwdata[7:0] & `RLC_CMP_A_MASK;
        `RLC_ADDR_CMP2_B:    s_d.cmp_b[1] = apb_req.pwdata[7:0] & `RLC_CMP_B_MASK;
        default: ;
      endcase
    end
    for (int i = 0; i < `RLC_NUM_CMP; i++) begin
      if (instr_cycle) begin
        s_d.latched[i] = raw[i];
      end
      s_d.tclk_prev[i] = timer_clk[i];
      if (s_q.tclk_prev[i] && !timer_clk[i]) begin
        s_d.synced[i] = s_q.latched[i];
      end
      s_d.prev_res[i] = s_q.latched[i];
      edge_rise = s_q.latched[i] && !s_q.prev_res[i];
      edge_fall = !s_q.latched[i] && s_q.prev_res[i];
      set_ev = (edge_rise && s_q.cmp_b[i][`RLC_BIT_RISE_EN]) ||
               (edge_fall && s_q.cmp_b[i][`RLC_BIT_FALL_EN]);
      // Write-one-to-clear; a new edge in the same cycle wins
      if (wr_en && apb_req.paddr == `RLC_ADDR_CMP_FLAG && apb_req.pwdata[i]) begin
        s_d.flag[i] = 1'b0;
      end
      if (set_ev) begin
        s_d.flag[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{ref_a: 8'h0_0, ref_level: 8'h0_0,
               cmp_a: {`RLC_CMP_A_RESET, `RLC_CMP_A_RESET},
               cmp_b: 16'h0000, latched: 2'h0, synced: 2'h0,
               tclk_prev: 2'h0, prev_res: 2'h0, flag: 2'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // Analog controls; low end of the ladder has no selector at all
  always_comb begin
    ladder_ctl.ladder_on           = s_q.ref_a[`RLC_BIT_LADDER_ON];
    ladder_ctl.ref_pin_drive       = s_q.ref_a[`RLC_BIT_PIN_DRIVE];
    ladder_ctl.ref_high_source_sel =
      rlc_hsrc_t'(s_q.ref_a[`RLC_BIT_HSRC_HI:`RLC_BIT_HSRC_LO]);
    ladder_ctl.level_code          = s_q.ref_level[4:0];
    for (int i = 0; i < `RLC_NUM_CMP; i++) begin
      cmp_ctl[i].cmp_on = s_q.cmp_a[i][`RLC_BIT_CMP_ON];
      cmp_ctl[i].speed  = s_q.cmp_a[i][`RLC_BIT_CMP_SPEED];
      cmp_ctl[i].hyst   = s_q.cmp_a[i][`RLC_BIT_CMP_HYS];
      cmp_ctl[i].cmp_plus_sel =
        rlc_plus_t'(s_q.cmp_b[i][`RLC_BIT_PLUS_HI:`RLC_BIT_PLUS_LO]);
      cmp_ctl[i].cmp_minus_sel =
        s_q.cmp_b[i][`RLC_BIT_MINUS_HI:`RLC_BIT_MINUS_LO];
    end
  end

  // Routed pin loses its digital functions
  assign ref_out_pin_oe        = 1'b0;
  assign ref_out_pin_pullup_en = !s_q.ref_a[`RLC_BIT_PIN_DRIVE];
  assign ref_out_pin_input_en  = !s_q.ref_a[`RLC_BIT_PIN_DRIVE];
  assign ref_pin_read = ref_pin_in && !s_q.ref_a[`RLC_BIT_PIN_DRIVE];

  always_comb begin
    for (int i = 0; i < `RLC_NUM_CMP; i++) begin
      cmp_result_synced[i] = s_q.cmp_a[i][`RLC_BIT_CMP_SYNC] ? s_q.synced[i]
                                                             : s_q.latched[i];
      cmp_result_raw[i]    = raw[i];
      cmp_pin_oe[i]  = !cmp_pin_direction[i] && s_q.cmp_a[i][`RLC_BIT_CMP_ON];
      cmp_pin_out[i] = cmp_pin_oe[i] && cmp_result_synced[i];
    end
  end

  assign cmp_event_flag = s_q.flag;

  // Assertions
  sequence s_fall0;
    $fell(timer_clk[0]);
  endsequence

  property p_ladder_off;
    @(posedge mclk) disable iff (sys_rst)
      !s_q.ref_a[`RLC_BIT_LADDER_ON] |-> !ladder_ctl.ladder_on;
  endproperty
  a_ladder_off: assert property (p_ladder_off) else $error("ladder on while disabled");

  property p_level_write;
    @(posedge mclk) disable iff (sys_rst)
      (wr_en && apb_req.paddr == `RLC_ADDR_REF_LEVEL)
        |=> ladder_ctl.level_code == $past(apb_req.pwdata[4:0]);
  endproperty
  a_level_write: assert property (p_level_write) else $error("level code not stored");

  property p_pin_read_zero;
    @(posedge mclk) disable iff (sys_rst)
      ladder_ctl.ref_pin_drive |-> !ref_pin_read && !ref_out_pin_input_en;
  endproperty
  a_pin_read_zero: assert property (p_pin_read_zero) else $error("routed pin reads one");

  property p_latch;
    @(posedge mclk) disable iff (sys_rst)
      instr_cycle |=> s_q.latched[0] == $past(raw[0]);
  endproperty
  a_latch: assert property (p_latch) else $error("result not latched");

  property p_hold;
    @(posedge mclk) disable iff (sys_rst)
      !instr_cycle |=> $stable(s_q.latched[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed off cycle");

  property p_pin_gate;
    @(posedge mclk) disable iff (sys_rst)
      (cmp_pin_direction[0] || !cmp_ctl[0].cmp_on) |-> !cmp_pin_oe[0] && !cmp_pin_out[0];
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("result pin driven");

  property p_invert;
    @(posedge mclk) disable iff (sys_rst)
      cmp_ctl[0].cmp_on |-> raw[0] == (cmp_decision[0] ^ s_q.cmp_a[0][`RLC_BIT_CMP_INV]);
  endproperty
  a_invert: assert property (p_invert) else $error("polarity wrong");

  property p_sync;
    @(posedge mclk) disable iff (sys_rst)
      s_fall0 |=> s_q.synced[0] == $past(s_q.latched[0]);
  endproperty
  a_sync: assert property (p_sync) else $error("sync capture missed");

  property p_rise_flag;
    @(posedge mclk) disable iff (sys_rst)
      ($rose(s_q.latched[0]) && s_q.cmp_b[0][`RLC_BIT_RISE_EN]) |=> cmp_event_flag[0];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising edge flag missed");

  // Multi-step behaviours built from named steps
  sequence s_ref_wr;
    wr_en && apb_req.paddr == `RLC_ADDR_REF_A;
  endsequence

  sequence s_cmp1b_wr;
    wr_en && apb_req.paddr == `RLC_ADDR_CMP1_B;
  endsequence

  sequence s_flag_clr0;
    wr_en && apb_req.paddr == `RLC_ADDR_CMP_FLAG && apb_req.pwdata[0];
  endsequence

  sequence s_fell_res0;
    $fell(s_q.latched[0]);
  endsequence

  property p_ladder_on;
    @(posedge mclk) disable iff (sys_rst)
      s_q.ref_a[`RLC_BIT_LADDER_ON] |-> ladder_ctl.ladder_on;
  endproperty
  a_ladder_on: assert property (p_ladder_on) else $error("ladder off while enabled");

  property p_hsrc_write;
    @(posedge mclk) disable iff (sys_rst)
      s_ref_wr |=> ladder_ctl.ref_high_source_sel == $past(apb_req.pwdata[3:2]);
  endproperty
  a_hsrc_write: assert property (p_hsrc_write) else $error("high source not stored");

  property p_drive_write;
    @(posedge mclk) disable iff (sys_rst)
      s_ref_wr |=> ladder_ctl.ref_pin_drive == $past(apb_req.pwdata[`RLC_BIT_PIN_DRIVE]);
  endproperty
  a_drive_write: assert property (p_drive_write) else $error("pin drive not stored");

  property p_pin_digital_off;
    @(posedge mclk) disable iff (sys_rst)
      ladder_ctl.ref_pin_drive |-> !ref_out_pin_pullup_en && !ref_out_pin_oe;
  endproperty
  a_pin_digital_off: assert property (p_pin_digital_off) else $error("routed pin digital on");

  property p_level_hold;
    @(posedge mclk) disable iff (sys_rst)
      !(wr_en && apb_req.paddr == `RLC_ADDR_REF_LEVEL) |=> $stable(ladder_ctl.level_code);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level code drifted");

  property p_ref_hold;
    @(posedge mclk) disable iff (sys_rst)
      !(wr_en && apb_req.paddr == `RLC_ADDR_REF_A) |=> $stable(s_q.ref_a);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference control drifted");

  // Reset clears the ladder controls even while reset is still held
  property p_reset_clear;
    @(posedge mclk) sys_rst |-> !ladder_ctl.ladder_on && !ladder_ctl.ref_pin_drive &&
                                ladder_ctl.level_code == 5'h0_0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left ladder on");

  property p_off_raw;
    @(posedge mclk) disable iff (sys_rst)
      !cmp_ctl[0].cmp_on |-> !cmp_result_raw[0];
  endproperty
  a_off_raw: assert property (p_off_raw) else $error("disabled comparator active");

  property p_plus_write;
    @(posedge mclk) disable iff (sys_rst)
      s_cmp1b_wr |=> cmp_ctl[0].cmp_plus_sel == $past(apb_req.pwdata[5:4]);
  endproperty
  a_plus_write: assert property (p_plus_write) else $error("plus select not stored");

  property p_minus_write;
    @(posedge mclk) disable iff (sys_rst)
      s_cmp1b_wr |=> cmp_ctl[0].cmp_minus_sel == $past(apb_req.pwdata[2:0]);
  endproperty
  a_minus_write: assert property (p_minus_write) else $error("minus select not stored");

  property p_mirror;
    @(posedge mclk) disable iff (sys_rst)
      (rd_en && apb_req.paddr == `RLC_ADDR_CMP_OUT) |-> apb_rsp.prdata[1:0] == s_q.latched;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror read wrong");

  property p_ctrl_result;
    @(posedge mclk) disable iff (sys_rst)
      (rd_en && apb_req.paddr == `RLC_ADDR_CMP1_A) |-> apb_rsp.prdata[6] == s_q.latched[0];
  endproperty
  a_ctrl_result: assert property (p_ctrl_result) else $error("result bit read wrong");

  property p_pin_follow;
    @(posedge mclk) disable iff (sys_rst)
      cmp_pin_oe[0] |-> cmp_pin_out[0] == cmp_result_synced[0];
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("result pin wrong");

  property p_async_path;
    @(posedge mclk) disable iff (sys_rst)
      !s_q.cmp_a[0][`RLC_BIT_CMP_SYNC] |-> cmp_result_synced[0] == s_q.latched[0];
  endproperty
  a_async_path: assert property (p_async_path) else $error("unsynced path wrong");

  property p_latch1;
    @(posedge mclk) disable iff (sys_rst)
      instr_cycle |=> s_q.latched[1] == $past(raw[1]);
  endproperty
  a_latch1: assert property (p_latch1) else $error("second result not latched");

  property p_invert1;
    @(posedge mclk) disable iff (sys_rst)
      cmp_ctl[1].cmp_on |-> raw[1] == (cmp_decision[1] ^ s_q.cmp_a[1][`RLC_BIT_CMP_INV]);
  endproperty
  a_invert1: assert property (p_invert1) else $error("second polarity wrong");

  property p_sync_hold;
    @(posedge mclk) disable iff (sys_rst)
      !$fell(timer_clk[0]) |=> $stable(s_q.synced[0]);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync changed off edge");

  property p_fall_flag;
    @(posedge mclk) disable iff (sys_rst)
      (s_fell_res0 ##0 s_q.cmp_b[0][`RLC_BIT_FALL_EN]) |=> cmp_event_flag[0];
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("falling edge flag missed");

  property p_flag_clear;
    @(posedge mclk) disable iff (sys_rst)
      (s_flag_clr0 ##0 s_q.latched[0] == s_q.prev_res[0]) |=> !cmp_event_flag[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_flag_quiet;
    @(posedge mclk) disable iff (sys_rst)
      (!cmp_event_flag[0] && s_q.latched[0] == s_q.prev_res[0]) |=> !cmp_event_flag[0];
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("flag set without edge");

endmodule : rlc_ctrl

`default_nettype wire

// [verilog/rlc_params.svh]
`ifndef RLC_PARAMS_SVH
`define RLC_PARAMS_SVH

// Register word addresses (byte offsets on APB)
`define RLC_ADDR_REF_A      12'h000
`define RLC_ADDR_REF_LEVEL  12'h004
`define RLC_ADDR_CMP1_A     12'h008
`define RLC_ADDR_CMP1_B     12'h00C
`define RLC_ADDR_CMP2_A     12'h010
`define RLC_ADDR_CMP2_B     12'h014
`define RLC_ADDR_CMP_OUT    12'h018
`define RLC_ADDR_CMP_FLAG   12'h01C

// Reference control A fields
`define RLC_BIT_LADDER_ON   7
`define RLC_BIT_PIN_DRIVE   5
`define RLC_BIT_HSRC_HI     3
`define RLC_BIT_HSRC_LO     2
`define RLC_REF_A_MASK      8'hA_C

// Comparator control A fields
`define RLC_BIT_CMP_ON      7
`define RLC_BIT_CMP_RES     6
`define RLC_BIT_CMP_INV     4
`define RLC_BIT_CMP_SPEED   2
`define RLC_BIT_CMP_HYS     1
`define RLC_BIT_CMP_SYNC    0
`define RLC_CMP_A_MASK      8'h9_7
`define RLC_CMP_A_RESET     8'h0_4

// Comparator control B fields
`define RLC_BIT_RISE_EN     7
`define RLC_BIT_FALL_EN     6
`define RLC_BIT_PLUS_HI     5
`define RLC_BIT_PLUS_LO     4
`define RLC_BIT_MINUS_HI    2
`define RLC_BIT_MINUS_LO    0
`define RLC_CMP_B_MASK      8'hF_7

`define RLC_LEVEL_MASK      8'h1_F
`define RLC_NUM_CMP         2

`endif

// [verilog/rlc_pkg.sv]
package rlc_pkg;
  typedef enum logic [1:0] {
    RLC_HSRC_SUPPLY = 2'h0,
    RLC_HSRC_PIN    = 2'h1,
    RLC_HSRC_TAP2   = 2'h2,
    RLC_HSRC_RSVD   = 2'h3
  } rlc_hsrc_t;

  typedef enum logic [1:0] {
    RLC_PLUS_PIN    = 2'h0,
    RLC_PLUS_LADDER = 2'h1,
    RLC_PLUS_TAP2   = 2'h2,
    RLC_PLUS_GND    = 2'h3
  } rlc_plus_t;

  // APB request and answer carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rlc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rlc_apb_rsp_t;

  // Analog-side controls of the reference ladder
  typedef struct packed {
    logic       ladder_on;
    logic       ref_pin_drive;
    rlc_hsrc_t  ref_high_source_sel;
    logic [4:0] level_code;
  } rlc_ladder_ctl_t;

  // Per-comparator analog-side controls
  typedef struct packed {
    logic       cmp_on;
    logic       speed;
    logic       hyst;
    rlc_plus_t  cmp_plus_sel;
    logic [2:0] cmp_minus_sel;
  } rlc_cmp_ctl_t;

  typedef struct packed {
    logic [7:0] ref_a;
    logic [7:0] ref_level;
    logic [1:0][7:0] cmp_a;
    logic [1:0][7:0] cmp_b;
    logic [1:0] latched;
    logic [1:0] synced;
    logic [1:0] tclk_prev;
    logic [1:0] prev_res;
    logic [1:0] flag;
  } rlc_state_t;
endpackage : rlc_pkg

// [testbench/rlc_analog_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Far side: comparator decisions, Timer1 clock after its prescaler, reference pin level
module rlc_analog_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] want,
  output var  logic [1:0] cmp_decision,
  output var  logic [1:0] timer_clk,
  output var  logic       ref_pin_in
);
  logic [2:0] div_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q        <= 3'h0;
      cmp_decision <= 2'h0;
      timer_clk    <= 2'h0;
      ref_pin_in   <= 1'b0;
    end else begin
      div_q        <= div_q + 3'h1;
      timer_clk    <= {2{div_q[2]}};
      cmp_decision <= want;
      // Toggles every cycle so a stale pin read can never match by luck
      ref_pin_in   <= ~ref_pin_in;
    end
  end
endmodule : rlc_analog_model
`default_nettype wire

// [testbench/tb_rlc_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rlc_params.svh"
module tb_rlc_ctrl;
  import rlc_pkg::*;
  logic                  mclk, sys_rst, instr_cycle, oe, pu, ie, prd, pin;
  rlc_apb_req_t          req;
  rlc_apb_rsp_t          rsp;
  rlc_ladder_ctl_t       lad;
  rlc_cmp_ctl_t [1:0]    cctl;
  logic [1:0]            want, dir, dec, tclk, syn, raw, pout, poe, flg, ic_cnt;
  int                    n_fail, check_count;
  logic [32:0]           expq[$];

  rlc_ctrl i_rlc_ctrl (.mclk(mclk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
    .instr_cycle(instr_cycle), .cmp_decision(dec), .timer_clk(tclk),
    .cmp_pin_direction(dir), .ref_pin_in(pin), .ladder_ctl(lad), .ref_out_pin_oe(oe),
    .ref_out_pin_pullup_en(pu), .ref_out_pin_input_en(ie), .ref_pin_read(prd),
    .cmp_ctl(cctl), .cmp_result_synced(syn), .cmp_result_raw(raw), .cmp_pin_out(pout),
    .cmp_pin_oe(poe), .cmp_event_flag(flg));
  rlc_analog_model i_rlc_analog_model (.mclk(mclk), .sys_rst(sys_rst), .want(want),
    .cmp_decision(dec), .timer_clk(tclk), .ref_pin_in(pin));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ic_cnt      <= ic_cnt + 2'h1;
    instr_cycle <= (ic_cnt == 2'h0);
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (rsp.pready !== 1'b1);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic set_dec(input logic [1:0] v);
    @(posedge mclk);
    want <= v;
    // Long enough for latch, a full timer period and the flag stage
    repeat (20) @(posedge mclk);
  endtask : set_dec

  always @(posedge mclk) begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1 && expq.size() > 0)
      chk({rsp.pslverr, rsp.prdata}, expq.pop_front());
  end
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end

  initial begin : main
    logic [7:0] ra, rl, ca, cb;
    logic [1:0] r;
    void'($urandom(32'h18b7_043b));
    req = '0;
    want = 2'h0;
    dir = 2'h3;
    ic_cnt = 2'h0;
    instr_cycle = 1'b0;
    sys_rst = 1'b1;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    chk({22'h0, lad, pu, ie}, {22'h0, 9'h000, 2'h3});
    for (int a = 0; a < 9; a++)
      rd(12'(a * 4), {a == 8, 24'h0, (a == 2 || a == 4) ? 8'h04 : 8'h00});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      ra = 8'($urandom);
      rl = 8'($urandom);
      ca = 8'($urandom) & 8'h17;
      cb = 8'($urandom);
      apb(1'b1, `RLC_ADDR_REF_A, {24'h0, ra});
      apb(1'b1, `RLC_ADDR_REF_LEVEL, {24'h0, rl});
      apb(1'b1, 12'(8 + (i % 2) * 8), {24'h0, ca});
      apb(1'b1, 12'(12 + (i % 2) * 8), {24'h0, cb});
      rd(`RLC_ADDR_REF_A, {25'h0, ra & `RLC_REF_A_MASK});
      rd(`RLC_ADDR_REF_LEVEL, {25'h0, rl & `RLC_LEVEL_MASK});
      rd(12'(8 + (i % 2) * 8), {25'h0, ca});
      rd(12'(12 + (i % 2) * 8), {25'h0, cb & `RLC_CMP_B_MASK});
      chk({24'h0, lad}, {24'h0, ra[7], ra[5], ra[3:2], rl[4:0]});
      chk({28'h0, cctl[i % 2].cmp_plus_sel, cctl[i % 2].cmp_minus_sel},
          {28'h0, cb[5:4], cb[2:0]});
    end
    $display("test registers done");
    apb(1'b1, `RLC_ADDR_REF_A, 32'h0000_00A0);
    @(negedge mclk);
    chk({29'h0, oe, pu, ie, prd}, 33'h0);
    apb(1'b1, `RLC_ADDR_REF_A, 32'h0000_0000);
    @(negedge mclk);
    chk({29'h0, oe, pu, ie, prd}, {29'h0, 3'h3, pin});
    $display("test reference pin done");
    apb(1'b1, `RLC_ADDR_CMP1_B, 32'h0000_0080);
    apb(1'b1, `RLC_ADDR_CMP2_B, 32'h0000_0080);
    dir <= 2'h0;
    r = 2'h0;
    for (int c = 0; c < 2; c++)
      for (int inv = 0; inv < 2; inv++)
        for (int d = 0; d < 2; d++) begin
          apb(1'b1, 12'(8 + c * 8), {24'h0, 8'h80 | 8'(inv << 4)});
          set_dec(c == 1 ? {d[0], want[0]} : {want[1], d[0]});
          r[c] = d[0] ^ inv[0];
          rd(12'(8 + c * 8), {25'h0, 1'b1, r[c], 1'b0, inv[0], 4'h0});
          rd(`RLC_ADDR_CMP_OUT, {31'h0, r});
          @(negedge mclk);
          chk({25'h0, raw, pout, poe, syn}, {25'h0, r, r, c == 1 ? 2'h3 : 2'h1, r});
        end
    $display("test comparator done");
    apb(1'b1, `RLC_ADDR_CMP_FLAG, 32'h0000_0003);
    rd(`RLC_ADDR_CMP_FLAG, 33'h0);
    set_dec(2'h2);
    rd(`RLC_ADDR_CMP_FLAG, 33'h1);
    apb(1'b1, `RLC_ADDR_CMP_FLAG, 32'h0000_0001);
    set_dec(2'h3);
    rd(`RLC_ADDR_CMP_FLAG, 33'h0);
    apb(1'b1, `RLC_ADDR_CMP1_B, 32'h0000_0040);
    set_dec(2'h2);
    rd(`RLC_ADDR_CMP_FLAG, 33'h0);
    set_dec(2'h3);
    rd(`RLC_ADDR_CMP_FLAG, 33'h1);
    chk({31'h0, flg}, 33'h1);
    $display("test flags done");
    set_dec(2'h2);
    apb(1'b1, `RLC_ADDR_CMP1_A, 32'h0000_0000);
    dir <= 2'h2;
    @(negedge mclk);
    chk({29'h0, raw[0], poe, pout[1]}, 33'h0);
    apb(1'b1, `RLC_ADDR_CMP2_A, 32'h0000_0081);
    set_dec(2'h0);
    @(negedge mclk);
    chk({32'h0, syn[1]}, 33'h0);
    set_dec(2'h2);
    @(negedge mclk);
    chk({32'h0, syn[1]}, 33'h1);
    $display("test disable and sync done");
    apb(1'b1, `RLC_ADDR_REF_A, 32'h0000_00A0);
    apb(1'b1, `RLC_ADDR_REF_LEVEL, 32'h0000_001F);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    chk({22'h0, lad, pu, ie}, {22'h0, 9'h000, 2'h3});
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : tb_rlc_ctrl
`default_nettype wire
